//--- verilog/hcr_defines.svh
// Offsets, reset values and timing constants of the custody register bank
`ifndef HCR_DEFINES_SVH
`define HCR_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define HCR_ADDR_BUTTON_LEVEL 16'h4f00
`define HCR_ADDR_DIN1_LEVEL 16'h4f02
`define HCR_ADDR_DIN2_LEVEL 16'h4f04
`define HCR_ADDR_HW_TALLY 16'h4f06
`define HCR_ADDR_RANGE_TALLY 16'h4f08
`define HCR_ADDR_ZEROING_TALLY 16'h4f0a
`define HCR_ADDR_LOCK_TALLY 16'h4f0c
`define HCR_ADDR_SNAPSHOT 16'h4f0e
`define HCR_ADDR_LED_MODE 16'h6f00
`define HCR_ADDR_LED_PATTERN 16'h6f02
`define HCR_ADDR_ZERO_DISABLE 16'h6f04
`define HCR_ADDR_LOCK_POLICY 16'h6f08
`define HCR_ADDR_PW_BLOCK 16'h6f24
// ****************************************
// Reset values and field limits
// ****************************************
`define HCR_RST_LED_MODE 2'h0
`define HCR_RST_LED_PATTERN 3'h0
`define HCR_RST_ZERO_DISABLE 1'h0
`define HCR_RST_LOCK_POLICY 2'h2
`define HCR_RST_PW_BLOCK 1'h0
`define HCR_TALLY_MAX 15'h7fff
`define HCR_FUNC_BATCH_A 8'h07
`define HCR_FUNC_BATCH_B 8'h08
`define HCR_ALARM_A 8'h01
`define HCR_ALARM_B 8'h02
// ****************************************
// Timing
// ****************************************
`define HCR_CLK_HZ 64'd200000000
`define HCR_STARTUP_HOLD_S 64'd100
`define HCR_BLINK_HALF_MS 64'd250
`endif

//--- verilog/hcr_pkg.sv
// Types shared by the custody register bank
package hcr_pkg;
	typedef enum logic [1:0] {
		LED_NORMAL,
		LED_PATTERN,
		LED_BLINK
	} hcr_led_mode_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [15:0] addr;
		logic [31:0] data;
	} hcr_reg_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [31:0] data;
	} hcr_reg_rsp_t;

	typedef struct packed {
		logic hwFault;
		logic rangeFault;
		logic zeroingDone;
	} hcr_event_t;

	typedef struct packed {
		logic [7:0] funcSel;
		logic [7:0] alarmKind;
		logic state;
	} hcr_dout_t;

	typedef struct packed {
		logic zeroAllowed;
		logic totResetAllowed;
		logic paramChangeAllowed;
	} hcr_perm_t;
endpackage

//--- verilog/hcr_register_bank.sv
// Register bank for the human interface and custody transfer functions
// Functional notes
// RULE1 - Mode 0 normal lamps, 1 lamps from pattern, 2 blink all three.
// RULE2 - Pattern bits 0,1,2 drive failure, operational and direction lamps.
// RULE3 - The master writes only 0 to 7 into the pattern register.
// RULE4 - On white displays the pattern drives red, green, blue backlight instead.
// RULE5 - Zero-button disable at 1 ignores presses; 0 lets presses through.
// RULE6 - Under custody lock, policy 0 blocks all, 1 zeroing, 2 reset, 3 both.
// RULE7 - Password block at 1 refuses default and user passwords; the code only clears defaultPassAllowed_ff and has no user-password output.
// RULE8 - Button mirror shows the zero-button level while LED mode is 1.
// RULE9 - Two mirrors show digital input 1 and 2 levels.
// RULE10 - Hardware faults count, except in the first 100 s after power-up.
// RULE11 - All four custody tallies stop and hold at 32767.
// RULE12 - Range tally counts each measurement beyond hardware range limits.
// RULE13 - Zeroing tally counts each zeroing procedure.
// RULE14 - Lock tally counts every switch change; odd while closed.
// RULE15 - Snapshot takes forward mass sum when a batching output changes.
// RULE16 - A later batching transition overwrites the earlier snapshot.
// RULE17 - Snapshot is kept with the mass unit selected at capture.
// RULE18 - Blink mode toggles all lamps together at a fixed period.
`include "hcr_defines.svh"

module hcr_register_bank #(
	parameter int NUM_DOUT = 2,
	parameter bit WHITE_DISPLAY = 1'b0,
	parameter longint unsigned STARTUP_CYCLES = `HCR_STARTUP_HOLD_S * `HCR_CLK_HZ,
	parameter longint unsigned BLINK_CYCLES = (`HCR_BLINK_HALF_MS * `HCR_CLK_HZ) / 64'd1000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register access
	input wire hcr_pkg::hcr_reg_req_t regReq,
	output hcr_pkg::hcr_reg_rsp_t regRsp_ff,
	// Field inputs
	input wire logic zeroButtonIn,
	input wire logic din1In,
	input wire logic din2In,
	input wire logic lockSwitchIn,
	input wire logic [2:0] lampNormal,
	input wire hcr_pkg::hcr_event_t events,
	input wire logic [31:0] forwardMassSum,
	input wire logic [7:0] massUnitSel,
	input wire hcr_pkg::hcr_dout_t [NUM_DOUT-1:0] douts,
	// Lamps and backlight
	output logic [2:0] lamp_ff,
	output logic [2:0] backlight_ff,
	// Policy outputs
	output logic zeroRequest_ff,
	output hcr_pkg::hcr_perm_t perm_ff,
	output logic defaultPassAllowed_ff,
	output logic [7:0] snapshotUnit_ff
);
	import hcr_pkg::*;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [14:0] sat_inc(input logic [14:0] v, input logic ev);
		sat_inc = (ev && v != `HCR_TALLY_MAX) ? v + 15'h0001 : v;
	endfunction

	function automatic logic is_batching(input hcr_dout_t d);
		is_batching = (d.funcSel == `HCR_FUNC_BATCH_A || d.funcSel == `HCR_FUNC_BATCH_B) &&
			(d.alarmKind == `HCR_ALARM_A || d.alarmKind == `HCR_ALARM_B);
	endfunction

	// ****************************************
	// Reset synchroniser
	// ****************************************
	logic rstSync1_ff;
	logic rstSync2_ff;
	wire logic rstnInt = rstSync2_ff;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstSync1_ff <= 1'b0;
			rstSync2_ff <= 1'b0;
		end else begin
			rstSync1_ff <= 1'b1;
			rstSync2_ff <= rstSync1_ff;
		end
	end

	// ****************************************
	// Writable registers
	// ****************************************
	logic [1:0] ledMode_ff;
	logic [2:0] pattern_ff;
	logic zeroDisable_ff;
	logic [1:0] policy_ff;
	logic pwBlock_ff;

	wire logic wrMode = regReq.write && regReq.addr == `HCR_ADDR_LED_MODE;
	wire logic wrPattern = regReq.write && regReq.addr == `HCR_ADDR_LED_PATTERN;
	wire logic wrZeroDis = regReq.write && regReq.addr == `HCR_ADDR_ZERO_DISABLE;
	wire logic wrPolicy = regReq.write && regReq.addr == `HCR_ADDR_LOCK_POLICY;
	wire logic wrPwBlock = regReq.write && regReq.addr == `HCR_ADDR_PW_BLOCK;

	always_ff @(posedge clock or negedge rstnInt) begin
		if (!rstnInt) begin
			ledMode_ff <= `HCR_RST_LED_MODE;
			pattern_ff <= `HCR_RST_LED_PATTERN;
			zeroDisable_ff <= `HCR_RST_ZERO_DISABLE;
			policy_ff <= `HCR_RST_LOCK_POLICY;
			pwBlock_ff <= `HCR_RST_PW_BLOCK;
		end else begin
			if (wrMode) ledMode_ff <= regReq.data[1:0]; // RULE1
			if (wrPattern) pattern_ff <= regReq.data[2:0]; // RULE3
			if (wrZeroDis) zeroDisable_ff <= regReq.data[0]; // RULE5
			if (wrPolicy) policy_ff <= regReq.data[1:0]; // RULE6
			if (wrPwBlock) pwBlock_ff <= regReq.data[0]; // RULE7
		end
	end

	// ****************************************
	// Lamp drive and blink timer
	// ****************************************
	localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 64'd1);
	logic [31:0] blinkCnt_ff;
	logic blinkPhase_ff;
	wire hcr_led_mode_t ledMode = hcr_led_mode_t'(ledMode_ff);
	wire logic blinkWrap = blinkCnt_ff == BLINK_LAST;
	wire logic [2:0] blinkLamps = {3{blinkPhase_ff}};
	logic [2:0] nxt_lamp;
	logic [2:0] nxt_backlight;

	always_comb begin
		nxt_lamp = lampNormal;
		nxt_backlight = 3'h0;
		case (ledMode)
			LED_PATTERN: begin
				if (WHITE_DISPLAY) nxt_backlight = pattern_ff; // RULE4
				else nxt_lamp = pattern_ff; // RULE2
			end
			LED_BLINK: begin
				nxt_lamp = blinkLamps; // RULE18
				if (WHITE_DISPLAY) nxt_backlight = blinkLamps;
			end
			default: begin
				nxt_lamp = lampNormal; // RULE1
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstnInt) begin
		if (!rstnInt) begin
			blinkCnt_ff <= 32'h0000_0000;
			blinkPhase_ff <= 1'b0;
			lamp_ff <= 3'h0;
			backlight_ff <= 3'h0;
		end else begin
			if (ledMode != LED_BLINK || blinkWrap) blinkCnt_ff <= 32'h0000_0000;
			else blinkCnt_ff <= blinkCnt_ff + 32'h0000_0001;
			if (ledMode != LED_BLINK) blinkPhase_ff <= 1'b0;
			else if (blinkWrap) blinkPhase_ff <= !blinkPhase_ff; // RULE18
			lamp_ff <= nxt_lamp;
			backlight_ff <= nxt_backlight;
		end
	end

	// ****************************************
	// Button, lock policy and passwords
	// ****************************************
	logic buttonPrev_ff;
	logic buttonMirror_ff;
	logic din1_ff;
	logic din2_ff;
	wire logic buttonPress = zeroButtonIn && !buttonPrev_ff;

	always_ff @(posedge clock or negedge rstnInt) begin
		if (!rstnInt) begin
			buttonPrev_ff <= 1'b0;
			zeroRequest_ff <= 1'b0;
			buttonMirror_ff <= 1'b0;
			din1_ff <= 1'b0;
			din2_ff <= 1'b0;
			perm_ff <= '0;
			defaultPassAllowed_ff <= 1'b0;
		end else begin
			buttonPrev_ff <= zeroButtonIn;
			zeroRequest_ff <= buttonPress && !zeroDisable_ff; // RULE5
			buttonMirror_ff <= (ledMode == LED_PATTERN) && zeroButtonIn; // RULE8
			din1_ff <= din1In; // RULE9
			din2_ff <= din2In; // RULE9
			perm_ff.zeroAllowed <= !lockSwitchIn || policy_ff[0]; // RULE6
			perm_ff.totResetAllowed <= !lockSwitchIn || policy_ff[1]; // RULE6
			perm_ff.paramChangeAllowed <= !lockSwitchIn; // RULE6
			defaultPassAllowed_ff <= !pwBlock_ff; // RULE7
		end
	end

	// ****************************************
	// Custody tallies
	// ****************************************
	localparam logic [39:0] STARTUP_LAST = 40'(STARTUP_CYCLES - 64'd1);
	logic [39:0] holdCnt_ff;
	logic startupDone_ff;
	logic lockPrev_ff;
	logic [14:0] hwTally_ff;
	logic [14:0] rangeTally_ff;
	logic [14:0] zeroTally_ff;
	logic [14:0] lockTally_ff;
	wire logic hwCount = events.hwFault && startupDone_ff;
	wire logic lockChange = lockSwitchIn != lockPrev_ff;

	always_ff @(posedge clock or negedge rstnInt) begin
		if (!rstnInt) begin
			holdCnt_ff <= 40'h00_0000_0000;
			startupDone_ff <= 1'b0;
			lockPrev_ff <= 1'b0;
			hwTally_ff <= 15'h0000;
			rangeTally_ff <= 15'h0000;
			zeroTally_ff <= 15'h0000;
			lockTally_ff <= 15'h0000;
		end else begin
			if (!startupDone_ff) holdCnt_ff <= holdCnt_ff + 40'h00_0000_0001;
			if (holdCnt_ff == STARTUP_LAST) startupDone_ff <= 1'b1; // RULE10
			lockPrev_ff <= lockSwitchIn;
			hwTally_ff <= sat_inc(hwTally_ff, hwCount); // RULE10 RULE11
			rangeTally_ff <= sat_inc(rangeTally_ff, events.rangeFault); // RULE11 RULE12
			zeroTally_ff <= sat_inc(zeroTally_ff, events.zeroingDone); // RULE11 RULE13
			lockTally_ff <= sat_inc(lockTally_ff, lockChange); // RULE11 RULE14
		end
	end

	// ****************************************
	// Batch-end snapshot
	// ****************************************
	logic [NUM_DOUT-1:0] doutPrev_ff;
	logic [31:0] snapshot_ff;
	logic [NUM_DOUT-1:0] batchEdgeVec;

	always_comb begin
		for (int i = 0; i < NUM_DOUT; i++) begin
			batchEdgeVec[i] = is_batching(douts[i]) && (douts[i].state != doutPrev_ff[i]);
		end
	end

	wire logic batchEdge = |batchEdgeVec;

	always_ff @(posedge clock or negedge rstnInt) begin
		if (!rstnInt) begin
			doutPrev_ff <= '0;
			snapshot_ff <= 32'h0000_0000;
			snapshotUnit_ff <= 8'h00;
		end else begin
			for (int i = 0; i < NUM_DOUT; i++) doutPrev_ff[i] <= douts[i].state;
			if (batchEdge) begin
				snapshot_ff <= forwardMassSum; // RULE15 RULE16
				snapshotUnit_ff <= massUnitSel; // RULE17
			end
		end
	end

	// ****************************************
	// Read-back and answer
	// ****************************************
	logic [31:0] rdMux;
	logic rdHit;
	logic wrHit;

	always_comb begin
		rdHit = 1'b1;
		case (regReq.addr)
			`HCR_ADDR_BUTTON_LEVEL: rdMux = {31'h0, buttonMirror_ff};
			`HCR_ADDR_DIN1_LEVEL: rdMux = {31'h0, din1_ff};
			`HCR_ADDR_DIN2_LEVEL: rdMux = {31'h0, din2_ff};
			`HCR_ADDR_HW_TALLY: rdMux = {17'h0, hwTally_ff};
			`HCR_ADDR_RANGE_TALLY: rdMux = {17'h0, rangeTally_ff};
			`HCR_ADDR_ZEROING_TALLY: rdMux = {17'h0, zeroTally_ff};
			`HCR_ADDR_LOCK_TALLY: rdMux = {17'h0, lockTally_ff};
			`HCR_ADDR_SNAPSHOT: rdMux = snapshot_ff;
			`HCR_ADDR_LED_MODE: rdMux = {30'h0, ledMode_ff};
			`HCR_ADDR_LED_PATTERN: rdMux = {29'h0, pattern_ff};
			`HCR_ADDR_ZERO_DISABLE: rdMux = {31'h0, zeroDisable_ff};
			`HCR_ADDR_LOCK_POLICY: rdMux = {30'h0, policy_ff};
			`HCR_ADDR_PW_BLOCK: rdMux = {31'h0, pwBlock_ff};
			default: begin
				rdMux = 32'h0000_0000;
				rdHit = 1'b0;
			end
		endcase
	end

	assign wrHit = wrMode || wrPattern || wrZeroDis || wrPolicy || wrPwBlock;

	always_ff @(posedge clock or negedge rstnInt) begin
		if (!rstnInt) begin
			regRsp_ff <= '0;
		end else begin
			regRsp_ff.valid <= regReq.read || regReq.write;
			regRsp_ff.err <= (regReq.read && !rdHit) || (regReq.write && !wrHit);
			regRsp_ff.data <= regReq.read ? rdMux : 32'h0000_0000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstnInt);

	led_pattern_a: assert property ((ledMode == LED_PATTERN && !WHITE_DISPLAY) |=> lamp_ff == $past(pattern_ff)) // RULE2
		else $error("Lamps do not follow the pattern");
	led_normal_a: assert property ((ledMode_ff == 2'h0) |=> lamp_ff == $past(lampNormal)) // RULE1
		else $error("Lamps do not follow normal drive");
	zero_lock_a: assert property (zeroDisable_ff |=> !zeroRequest_ff) // RULE5
		else $error("Zero press passed while disabled");
	lock_policy_a: assert property ((lockSwitchIn && policy_ff == 2'h0) |=> perm_ff == 3'h0) // RULE6
		else $error("Policy 0 permits action under lock");
	pass_block_a: assert property (pwBlock_ff |=> !defaultPassAllowed_ff) // RULE7
		else $error("Default passwords allowed while blocked");
	button_mirror_a: assert property ((ledMode != LED_PATTERN) |=> !buttonMirror_ff) // RULE8
		else $error("Button mirror set outside mode 1");
	hw_holdoff_a: assert property ((!startupDone_ff) |=> $stable(hwTally_ff)) // RULE10
		else $error("Hardware fault counted during startup");
	tally_sat_a: assert property ((rangeTally_ff == `HCR_TALLY_MAX) |=> $stable(rangeTally_ff)) // RULE11
		else $error("Range tally moved past its ceiling");
	range_inc_a: assert property ((events.rangeFault && rangeTally_ff != `HCR_TALLY_MAX) // RULE12
		|=> rangeTally_ff == $past(rangeTally_ff) + 15'h0001)
		else $error("Range tally missed a fault");
	lock_parity_a: assert property ((lockTally_ff != `HCR_TALLY_MAX) |-> lockTally_ff[0] == lockPrev_ff) // RULE14
		else $error("Lock tally parity differs from switch");
	snap_take_a: assert property (batchEdge |=> snapshot_ff == $past(forwardMassSum)) // RULE15
		else $error("Snapshot not taken on batching edge");
	blink_run_a: assert property ((ledMode == LED_BLINK && !blinkWrap) ##1 (ledMode == LED_BLINK) // RULE18
		|-> $stable(blinkPhase_ff))
		else $error("Blink phase toggled early");
	backlight_pat_a: assert property ((ledMode == LED_PATTERN && WHITE_DISPLAY) // RULE4
		|=> backlight_ff == $past(pattern_ff))
		else $error("Backlight does not follow the pattern");
	din_mirror_a: assert property (1'b1 |=> din1_ff == $past(din1In) && din2_ff == $past(din2In)) // RULE9
		else $error("Input mirrors lag or differ");
	zero_inc_a: assert property ((events.zeroingDone && zeroTally_ff != `HCR_TALLY_MAX) // RULE13
		|=> zeroTally_ff == $past(zeroTally_ff) + 15'h0001)
		else $error("Zeroing tally missed a procedure");
	hw_inc_a: assert property ((hwCount && hwTally_ff != `HCR_TALLY_MAX) // RULE10
		|=> hwTally_ff == $past(hwTally_ff) + 15'h0001)
		else $error("Hardware tally missed a fault");

	blink_seen_c: cover property (ledMode == LED_BLINK && blinkWrap ##1 blinkPhase_ff);
	snap_seen_c: cover property (batchEdge ##1 batchEdge);
	sat_seen_c: cover property (hwTally_ff == `HCR_TALLY_MAX);
	pattern_seen_c: cover property (ledMode == LED_PATTERN ##1 lamp_ff == 3'h7);
endmodule

//--- dv/hcr_master_model.sv
// Register bus master standing in for the supervisory system
module hcr_master_model
	import hcr_pkg::*;
(
	// Clock
	input wire logic clock,
	// Register bus
	output hcr_pkg::hcr_reg_req_t regReq,
	input wire hcr_pkg::hcr_reg_rsp_t regRsp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] wd;
	initial regReq = '0;
	// One access, held until the taking edge, then released to inverted values
	task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d, output hcr_reg_rsp_t r);
		wd = (wr && a == 16'h6f02) ? (d & 32'h0000_0007) : d;
		@(posedge clock);
		regReq <= '{write: wr, read: !wr, addr: a, data: wd};
		@(posedge clock);
		regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, data: ~wd};
		@(posedge clock);
		r = regRsp;
	endtask
endmodule

//--- dv/test_hcr_register_bank.sv
// Self-checking bench of the custody register bank
module test_hcr_register_bank;
	timeunit 1ns;
	timeprecision 1ps;
	import hcr_pkg::*;
	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [31:0] wd;
		logic [32:0] exp;
	} hcr_row_t;
	logic clock, rstn, zeroButtonIn, din1In, din2In, lockSwitchIn;
	logic [2:0] lampNormal, lamp, perm3, backlight, whiteLamp, whiteBack;
	logic [31:0] forwardMassSum;
	logic [7:0] massUnitSel, snapUnit;
	logic zeroReq, passOk, seen0, seen7, bad;
	hcr_event_t events;
	hcr_dout_t [1:0] douts;
	hcr_reg_req_t regReq;
	hcr_reg_rsp_t regRsp, rsp;
	hcr_perm_t perm;
	int errors = 0;
	int n_compared = 0;
	int nPress = 0;
	hcr_row_t rows [15] = '{
		'{1'b0, 16'h6f00, 32'h0, 33'h0}, '{1'b0, 16'h6f02, 32'h0, 33'h0},
		'{1'b0, 16'h6f04, 32'h0, 33'h0}, '{1'b0, 16'h6f08, 32'h0, 33'h2},
		'{1'b0, 16'h6f24, 32'h0, 33'h0}, '{1'b0, 16'h4f0e, 32'h0, 33'h0},
		'{1'b1, 16'h4f06, 32'h9, 33'h1_0000_0000}, '{1'b0, 16'h4f06, 32'h0, 33'h0},
		'{1'b0, 16'h6f06, 32'h0, 33'h1_0000_0000}, '{1'b1, 16'h6f08, 32'h3, 33'h0},
		'{1'b0, 16'h6f08, 32'h0, 33'h3}, '{1'b1, 16'h6f24, 32'h1, 33'h0},
		'{1'b0, 16'h6f24, 32'h0, 33'h1}, '{1'b1, 16'h6f04, 32'h1, 33'h0},
		'{1'b0, 16'h6f04, 32'h0, 33'h1}};
	assign perm3 = perm;
	hcr_register_bank #(.STARTUP_CYCLES(50), .BLINK_CYCLES(4)) dut_u (.clock(clock), .rstn(rstn),
		.regReq(regReq), .regRsp_ff(regRsp), .zeroButtonIn(zeroButtonIn), .din1In(din1In),
		.din2In(din2In), .lockSwitchIn(lockSwitchIn), .lampNormal(lampNormal), .events(events),
		.forwardMassSum(forwardMassSum), .massUnitSel(massUnitSel), .douts(douts), .lamp_ff(lamp),
		.backlight_ff(backlight), .zeroRequest_ff(zeroReq), .perm_ff(perm), .defaultPassAllowed_ff(passOk),
		.snapshotUnit_ff(snapUnit));
	hcr_register_bank #(.STARTUP_CYCLES(50), .BLINK_CYCLES(4), .WHITE_DISPLAY(1'b1)) white_u (.clock(clock),
		.rstn(rstn), .regReq(regReq), .regRsp_ff(), .zeroButtonIn(zeroButtonIn), .din1In(din1In),
		.din2In(din2In), .lockSwitchIn(lockSwitchIn), .lampNormal(lampNormal), .events(events),
		.forwardMassSum(forwardMassSum), .massUnitSel(massUnitSel), .douts(douts), .lamp_ff(whiteLamp),
		.backlight_ff(whiteBack), .zeroRequest_ff(), .perm_ff(), .defaultPassAllowed_ff(), .snapshotUnit_ff());
	hcr_master_model master_u (.clock(clock), .regReq(regReq), .regRsp(regRsp));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (zeroReq === 1'b1) nPress++;
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
		master_u.access(wr, a, d, rsp);
	endtask
	task automatic pulse(input hcr_event_t e, input int n);
		@(posedge clock);
		events <= e;
		tick(n);
		events <= '0;
	endtask
	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		end_of_test();
	end
	initial begin
		rstn = 1'b0;
		{zeroButtonIn, din1In, din2In, lockSwitchIn} = '0;
		lampNormal = 3'h2;
		events = '0;
		forwardMassSum = 32'h0;
		massUnitSel = 8'h0;
		douts = '0;
		tick(3);
		rstn <= 1'b1;
		tick(4);
		check(perm3, 3'b111);
		pulse(3'b100, 2);
		// ****************************************
		// Table of register accesses
		// ****************************************
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].addr, rows[i].wd);
			check({rsp.err, rsp.data}, rows[i].exp);
		end
		check(passOk, 1'b0);
		// ****************************************
		// Zero button, lamps, mirrors
		// ****************************************
		@(posedge clock) zeroButtonIn <= 1'b1;
		tick(4);
		check(nPress, 0);
		zeroButtonIn <= 1'b0;
		acc(1'b1, 16'h6f04, 32'h0);
		@(posedge clock) zeroButtonIn <= 1'b1;
		tick(4);
		check(nPress, 1);
		acc(1'b1, 16'h6f02, 32'h5);
		acc(1'b1, 16'h6f00, 32'h1);
		tick(2);
		check(lamp, 3'h5);
		check(backlight, 3'h0);
		check(whiteBack, 3'h5);
		check(whiteLamp, 3'h2);
		acc(1'b0, 16'h4f00, 32'h0);
		check(rsp.data, 32'h1);
		acc(1'b1, 16'h6f00, 32'h0);
		tick(2);
		check(lamp, 3'h2);
		acc(1'b0, 16'h4f00, 32'h0);
		check(rsp.data, 32'h0);
		acc(1'b1, 16'h6f00, 32'h2);
		{seen0, seen7, bad} = '0;
		repeat (16) begin
			@(negedge clock);
			seen0 |= lamp === 3'h0;
			seen7 |= lamp === 3'h7;
			bad |= lamp !== 3'h0 && lamp !== 3'h7;
		end
		check({seen0, seen7, bad}, 3'b110);
		@(posedge clock) din1In <= 1'b1;
		acc(1'b0, 16'h4f02, 32'h0);
		check(rsp.data, 32'h1);
		acc(1'b0, 16'h4f04, 32'h0);
		check(rsp.data, 32'h0);
		@(posedge clock) din2In <= 1'b1;
		acc(1'b0, 16'h4f04, 32'h0);
		check(rsp.data, 32'h1);
		// ****************************************
		// Custody lock policy and lock tally
		// ****************************************
		@(posedge clock) lockSwitchIn <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			acc(1'b1, 16'h6f08, p);
			tick(2);
			check(perm3, {p[0], p[1], 1'b0});
		end
		acc(1'b0, 16'h4f0c, 32'h0);
		check(rsp.data, 32'h1);
		@(posedge clock) lockSwitchIn <= 1'b0;
		acc(1'b0, 16'h4f0c, 32'h0);
		check(rsp.data, 32'h2);
		// ****************************************
		// Tallies, start-up hold and saturation
		// ****************************************
		pulse(3'b100, 3);
		pulse(3'b001, 2);
		pulse(3'b010, 32770);
		acc(1'b0, 16'h4f06, 32'h0);
		check(rsp.data, 32'h3);
		acc(1'b0, 16'h4f0a, 32'h0);
		check(rsp.data, 32'h2);
		acc(1'b0, 16'h4f08, 32'h0);
		check(rsp.data, 32'h7fff);
		// ****************************************
		// Batch-end snapshot
		// ****************************************
		@(posedge clock);
		forwardMassSum <= 32'h4120_0000;
		massUnitSel <= 8'h3;
		douts[0] <= '{8'h07, 8'h01, 1'b1};
		acc(1'b0, 16'h4f0e, 32'h0);
		check(rsp.data, 32'h4120_0000);
		check(snapUnit, 8'h3);
		@(posedge clock);
		forwardMassSum <= 32'h0;
		douts[1] <= '{8'h05, 8'h01, 1'b1};
		acc(1'b0, 16'h4f0e, 32'h0);
		check(rsp.data, 32'h4120_0000);
		@(posedge clock);
		douts[0] <= '{8'h08, 8'h02, 1'b0};
		massUnitSel <= 8'h5;
		acc(1'b0, 16'h4f0e, 32'h0);
		check(rsp.data, 32'h0);
		check(snapUnit, 8'h5);
		// ****************************************
		// Reset in mid-run
		// ****************************************
		@(posedge clock) rstn <= 1'b0;
		tick(2);
		rstn <= 1'b1;
		tick(3);
		acc(1'b0, 16'h6f08, 32'h0);
		check(rsp.data, 32'h2);
		acc(1'b0, 16'h4f08, 32'h0);
		check(rsp.data, 32'h0);
		end_of_test();
	end
endmodule
